// >>> core/cfg_wdt_map.svh
// Offsets, field positions, reset values and timing counts for the
// configuration word and watchdog block.
// Assumes inclusion by bare name from core/ files only.
`ifndef CFG_WDT_MAP_SVH
`define CFG_WDT_MAP_SVH

// --------------------------------------------------------------------
// Addresses
// --------------------------------------------------------------------
`define CW_STATUS_OFS      8'h06
`define CW_CFG_BASE_HI     12'hfe0
`define CW_CFG_LOW_OFS     16'hfe00
`define CW_CFG_HIGH_OFS    16'hfe08

// --------------------------------------------------------------------
// Configuration word: bit index in the 16-bit word (high byte = +8)
// --------------------------------------------------------------------
`define CW_OSC0_BIT        0
`define CW_OSC1_BIT        1
`define CW_PS0_BIT         2
`define CW_PS1_BIT         3
`define CW_PM0_BIT         4
`define CW_PM1_BIT         6
`define CW_BOD_BIT         14
`define CW_PM2_BIT         15
`define CW_IMPL_MASK       16'hc05f
`define CW_FUSE_ERASED     16'hffff
`define CW_LATCH_HIGH_VAL  8'hff

// --------------------------------------------------------------------
// Status register fields
// --------------------------------------------------------------------
`define CW_STS_TO_BIT      3
`define CW_STS_PD_BIT      2
`define CW_STS_RESET       8'h3c
`define CW_STS_SW_MASK     8'h33

// --------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------
`define CW_CLK_NS          40
`define CW_POWER_UP_TIMER_MS         96
`define CW_WDT_MS          12
`define CW_RC_TICK_NS      46875
`define CW_WDT_BASE_TICKS  ((`CW_WDT_MS * 1000000) / `CW_RC_TICK_NS)
`define CW_POWER_UP_TIMER_CYCLES     ((`CW_POWER_UP_TIMER_MS * 1000000) / `CW_CLK_NS)
`define CW_TMR_OVF_CYCLES  65536
`define CW_POST_64         8'h3f
`define CW_POST_256        8'hff

`endif

// >>> core/cfg_wdt_pkg.sv
// Types shared by the configuration word and watchdog files.
// Assumes nothing beyond a SystemVerilog compiler.
package cfg_wdt_pkg;

    // Processor modes decoded from the three mode bits
    typedef enum logic [2:0] {
        PM_MICROPROCESSOR,
        PM_MICROCONTROLLER,
        PM_EXTENDED_MCU,
        PM_PROTECTED_MCU,
        PM_RESERVED
    } proc_mode_t;

    // Oscillator modes
    typedef enum logic [1:0] {
        OSC_EXTERNAL_CLOCK,
        OSC_CRYSTAL_RESONATOR,
        OSC_RESISTOR_CAPACITOR,
        OSC_LOW_POWER_CRYSTAL
    } osc_mode_t;

    // Watchdog postscale choices
    typedef enum logic [1:0] {
        WD_POST_1,
        WD_POST_64,
        WD_POST_256,
        WD_OFF_TIMER
    } wdt_post_t;

    // Decoded configuration carried to the rest of the chip
    typedef struct packed {
        proc_mode_t processor_mode;
        logic       brownout_detect_enable;
        wdt_post_t  watchdog_postscale;
        osc_mode_t  osc_mode;
    } cfg_decoded_t;

    // Table access from the core
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } table_req_t;

    // Core instruction events
    typedef struct packed {
        logic clear_wdt;
        logic sleep;
        logic wake;
    } core_event_t;

endpackage

// >>> core/config_fuse_mem.sv
// Sixteen configuration cells, eight of them one-time programmable.
// Assumes program requests are already qualified by the caller.
`timescale 1ns/1ps
`include "cfg_wdt_map.svh"

module config_fuse_mem (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Program port
    input  wire logic        prog_en,
    input  wire logic [3:0]  prog_idx,
    // Stored word
    output logic      [15:0] word_q
);

    // ----------------------------------------------------------------
    // Cell array
    // ----------------------------------------------------------------
    // Erased level and implemented-cell mask as indexable constants
    localparam logic [15:0] ERASED_WORD = `CW_FUSE_ERASED;
    localparam logic [15:0] IMPL_MASK   = `CW_IMPL_MASK;

    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_cell
            // A cell goes from erased 1 to programmed 0, and back to 1 only on arst_n
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    word_q[i] <= ERASED_WORD[i];
                end else if (prog_en && prog_idx == 4'(i)
                             && IMPL_MASK[i]) begin
                    word_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule

// >>> core/config_word_and_watchdog.sv
// Configuration word with table access, watchdog and power-up timer.
// Assumes the core issues one-cycle instruction strobes on clk, and the
// watchdog oscillator and programming-voltage detect arrive as pins.
`timescale 1ns/1ps
`include "cfg_wdt_map.svh"

module config_word_and_watchdog #(
    parameter int unsigned POWER_UP_TIMER_CYCLES = `CW_POWER_UP_TIMER_CYCLES
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    // Pins from outside the clock domain
    input  wire logic                       wdt_rc_osc,
    input  wire logic                       prog_voltage_high,
    input  wire logic                       prog_tool_mode,
    // Core side
    input  wire cfg_wdt_pkg::table_req_t    table_req,
    input  wire cfg_wdt_pkg::core_event_t   core_evt,
    input  wire logic                       core_in_reset,
    input  wire logic                       sts_wr,
    input  wire logic [7:0]                 sts_addr,
    input  wire logic [7:0]                 sts_wdata,
    // Table latches
    output logic      [7:0]                 table_latch_low,
    output logic      [7:0]                 table_latch_high,
    output logic                            table_hit,
    // Status and reset
    output logic      [7:0]                 cpu_status_register,
    output logic                            wdt_reset_req,
    output logic                            power_up_hold,
    // Decoded configuration
    output cfg_wdt_pkg::cfg_decoded_t       cfg_decoded,
    output logic                            cfg_in_space
);

    // ----------------------------------------------------------------
    // Decode functions
    // ----------------------------------------------------------------
    // Address falls inside the sixteen configuration locations
    function automatic logic in_cfg_range(input logic [15:0] a);
        return a[15:4] == `CW_CFG_BASE_HI;
    endfunction

    // Processor mode from the three mode bits
    function automatic cfg_wdt_pkg::proc_mode_t pm_decode(
        input logic [2:0] pm);
        unique case (pm)
            3'b111:  return cfg_wdt_pkg::PM_MICROPROCESSOR;
            3'b110:  return cfg_wdt_pkg::PM_MICROCONTROLLER;
            3'b101:  return cfg_wdt_pkg::PM_EXTENDED_MCU;
            3'b000:  return cfg_wdt_pkg::PM_PROTECTED_MCU;
            default: return cfg_wdt_pkg::PM_RESERVED;
        endcase
    endfunction

    // Postscale choice from the two select bits
    function automatic cfg_wdt_pkg::wdt_post_t ps_decode(
        input logic [1:0] ps);
        unique case (ps)
            2'b11: return cfg_wdt_pkg::WD_POST_1;
            2'b10: return cfg_wdt_pkg::WD_POST_256;
            2'b01: return cfg_wdt_pkg::WD_POST_64;
            2'b00: return cfg_wdt_pkg::WD_OFF_TIMER;
        endcase
    endfunction

    // Oscillator mode from the two select bits
    function automatic cfg_wdt_pkg::osc_mode_t osc_decode(
        input logic [1:0] osc);
        unique case (osc)
            2'b11: return cfg_wdt_pkg::OSC_EXTERNAL_CLOCK;
            2'b10: return cfg_wdt_pkg::OSC_CRYSTAL_RESONATOR;
            2'b01: return cfg_wdt_pkg::OSC_RESISTOR_CAPACITOR;
            2'b00: return cfg_wdt_pkg::OSC_LOW_POWER_CRYSTAL;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam logic [15:0] BASE_LAST = 16'(`CW_WDT_BASE_TICKS - 1);
    localparam logic [15:0] TMR_LAST  = 16'(`CW_TMR_OVF_CYCLES - 1);
    localparam logic [21:0] POWER_UP_TIMER_LAST = 22'(POWER_UP_TIMER_CYCLES - 1);

    typedef enum logic {PWR_HOLD, PWR_RUN} pwr_state_t;

    logic [2:0]       rc_sync_reg;      // Oscillator synchroniser + edge
    logic [1:0]       vpp_sync_reg;     // Programming voltage sync
    logic [1:0]       tool_sync_reg;    // Programming tool sync
    logic [15:0]      fuse_word;        // Stored configuration word
    logic [15:0]      base_cnt;         // Watchdog base count
    logic [7:0]       post_reg;         // Postscaler
    logic             asleep_reg;       // Core is in sleep
    logic [21:0]      power_up_timer_cnt_reg;     // Power-up count
    pwr_state_t       pwr_state_reg;    // Power-up state
    logic             rc_tick;          // One clk per oscillator rise
    logic             wdt_on;           // Watchdog mode selected
    logic             base_inc;         // Advance base count
    logic             base_wrap;        // Base period complete
    logic             time_out;         // Full time-out reached
    logic             wdt_clr;          // Clear counter and postscaler
    logic             cfg_wr_ok;        // Qualified program request
    logic             cfg_rd_ok;        // Qualified config read
    logic             visible;          // Config in program space
    cfg_wdt_pkg::wdt_post_t post_sel;   // Current postscale choice

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Two flops each before any logic looks at the pin
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rc_sync_reg   <= 3'h0;
            vpp_sync_reg  <= 2'h0;
            tool_sync_reg <= 2'h0;
        end else begin
            rc_sync_reg   <= {rc_sync_reg[1:0], wdt_rc_osc};
            vpp_sync_reg  <= {vpp_sync_reg[0], prog_voltage_high};
            tool_sync_reg <= {tool_sync_reg[0], prog_tool_mode};
        end
    end

    // Rising edge of the free-running watchdog oscillator
    assign rc_tick = rc_sync_reg[1] & ~rc_sync_reg[2];

    // ----------------------------------------------------------------
    // Configuration cells
    // ----------------------------------------------------------------
    // Programming needs the table write and the high voltage together;
    // the data value is ignored on purpose
    assign cfg_wr_ok = table_req.wr && in_cfg_range(table_req.addr)
                       && vpp_sync_reg[1];

    config_fuse_mem u_fuse (
        .clk      (clk),
        .arst_n   (arst_n),
        .prog_en  (cfg_wr_ok),
        .prog_idx (table_req.addr[3:0]),
        .word_q   (fuse_word)
    );

    // Space visibility: microcontroller or protected modes only
    assign visible = pm_decode({fuse_word[`CW_PM2_BIT],
                                fuse_word[`CW_PM1_BIT],
                                fuse_word[`CW_PM0_BIT]})
                     inside {cfg_wdt_pkg::PM_MICROCONTROLLER,
                             cfg_wdt_pkg::PM_PROTECTED_MCU};

    // A programming tool reads regardless of mode
    assign cfg_rd_ok = table_req.rd && in_cfg_range(table_req.addr)
                       && (visible || tool_sync_reg[1]);

    // ----------------------------------------------------------------
    // Decoded configuration outputs
    // ----------------------------------------------------------------
    // Registered every cycle from the stored cells
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_decoded  <= '{cfg_wdt_pkg::PM_MICROPROCESSOR, 1'b1,
                              cfg_wdt_pkg::WD_POST_1,
                              cfg_wdt_pkg::OSC_EXTERNAL_CLOCK};
            cfg_in_space <= 1'b0;
        end else begin
            cfg_decoded.processor_mode <=
                pm_decode({fuse_word[`CW_PM2_BIT], fuse_word[`CW_PM1_BIT],
                           fuse_word[`CW_PM0_BIT]});
            cfg_decoded.brownout_detect_enable <=
                fuse_word[`CW_BOD_BIT];
            cfg_decoded.watchdog_postscale <=
                ps_decode({fuse_word[`CW_PS1_BIT],
                           fuse_word[`CW_PS0_BIT]});
            cfg_decoded.osc_mode <=
                osc_decode({fuse_word[`CW_OSC1_BIT],
                            fuse_word[`CW_OSC0_BIT]});
            cfg_in_space <= visible;
        end
    end

    // ----------------------------------------------------------------
    // Table read latches
    // ----------------------------------------------------------------
    // Byte chosen by address bit 3; unimplemented bits read as 1
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            table_latch_low  <= 8'hff;
            table_latch_high <= 8'hff;
            table_hit        <= 1'b0;
        end else begin
            table_hit <= cfg_rd_ok;
            if (cfg_rd_ok) begin
                if (table_req.addr[3]) begin
                    table_latch_low <= fuse_word[15:8];
                end else begin
                    table_latch_low <= fuse_word[7:0];
                end
                table_latch_high <= `CW_LATCH_HIGH_VAL;
            end
        end
    end

    // ----------------------------------------------------------------
    // Power-up timer
    // ----------------------------------------------------------------
    // Holds the device after every arst_n reset; core_in_reset does not restart it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pwr_state_reg <= PWR_HOLD;
            power_up_timer_cnt_reg  <= 22'h000000;
            power_up_hold <= 1'b1;
        end else begin
            unique case (pwr_state_reg)
                PWR_HOLD: begin
                    if (power_up_timer_cnt_reg == POWER_UP_TIMER_LAST) begin
                        pwr_state_reg <= PWR_RUN;
                        power_up_hold <= 1'b0;
                    end else begin
                        power_up_timer_cnt_reg <= power_up_timer_cnt_reg + 22'h000001;
                    end
                end
                PWR_RUN: begin
                    power_up_hold <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Sleep tracking
    // ----------------------------------------------------------------
    // Wake or reset ends sleep; the sleep strobe starts it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            asleep_reg <= 1'b0;
        end else if (core_evt.sleep) begin
            asleep_reg <= 1'b1;
        end else if (core_evt.wake || core_in_reset || wdt_reset_req) begin
            asleep_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Watchdog count
    // ----------------------------------------------------------------
    assign post_sel = cfg_decoded.watchdog_postscale;
    assign wdt_on   = post_sel != cfg_wdt_pkg::WD_OFF_TIMER;

    // Watchdog counts oscillator ticks; plain timer counts clk when awake
    assign base_inc = wdt_on ? rc_tick : ~asleep_reg;

    // End of one base period, or timer overflow
    assign base_wrap = base_inc &&
                       (wdt_on ? base_cnt == BASE_LAST
                               : base_cnt == TMR_LAST);

    // Full time-out after the chosen number of base periods
    always_comb begin
        unique case (post_sel)
            cfg_wdt_pkg::WD_POST_64:  time_out = base_wrap &&
                                                 post_reg == `CW_POST_64;
            cfg_wdt_pkg::WD_POST_256: time_out = base_wrap &&
                                                 post_reg == `CW_POST_256;
            default:                  time_out = base_wrap;
        endcase
    end

    // Held clear in reset and by clear, sleep, wake or own reset
    assign wdt_clr = core_in_reset || power_up_hold
                     || core_evt.clear_wdt || core_evt.sleep
                     || core_evt.wake || wdt_reset_req;
    // Base wrap restarts only the base counter below; putting it in this
    // clear would mask every time-out in every postscale choice, since each needs a base wrap

    wdt_counter u_base (
        .clk    (clk),
        .arst_n (arst_n),
        .clr    (wdt_clr || base_wrap),
        .inc    (base_inc),
        .cnt_q  (base_cnt)
    );

    // Postscaler counts base periods; cleared with the counter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            post_reg <= 8'h00;
        end else if (wdt_clr || time_out) begin
            post_reg <= 8'h00;
        end else if (base_wrap) begin
            post_reg <= post_reg + 8'h01;
        end
    end

    // Device reset request, only in watchdog mode
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wdt_reset_req <= 1'b0;
        end else begin
            wdt_reset_req <= time_out && wdt_on && !wdt_clr;
        end
    end

    // ----------------------------------------------------------------
    // Status register
    // ----------------------------------------------------------------
    // Any clear source in the same cycle wins over a time-out
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_status_register <= `CW_STS_RESET;
        end else begin
            if (sts_wr && sts_addr == `CW_STATUS_OFS) begin
                cpu_status_register <=
                    (cpu_status_register & ~`CW_STS_SW_MASK)
                    | (sts_wdata & `CW_STS_SW_MASK);
            end
            if (time_out && !wdt_clr) begin
                cpu_status_register[`CW_STS_TO_BIT] <= 1'b0;
            end else if (core_evt.sleep) begin
                cpu_status_register[`CW_STS_TO_BIT] <= 1'b1;
                cpu_status_register[`CW_STS_PD_BIT] <= 1'b0;
            end else if (core_evt.clear_wdt) begin
                cpu_status_register[`CW_STS_TO_BIT] <= 1'b1;
                cpu_status_register[`CW_STS_PD_BIT] <= 1'b1;
            end
        end
    end

endmodule

// >>> core/wdt_counter.sv
// Clearable up-counter used for the watchdog base count.
// Assumes clear and increment come from the same clock domain.
`timescale 1ns/1ps

module wdt_counter (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Control
    input  wire logic        clr,
    input  wire logic        inc,
    // Count
    output logic      [15:0] cnt_q
);

    // ----------------------------------------------------------------
    // Count register
    // ----------------------------------------------------------------
    // Clear wins over increment
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 16'h0000;
        end else if (clr) begin
            cnt_q <= 16'h0000;
        end else if (inc) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

endmodule

// >>> dv/cfg_wdt_asserts.sv
// Port checker for the configuration word and watchdog top.
// Assumes it is bound onto config_word_and_watchdog.
`timescale 1ns/1ps
module cfg_wdt_asserts (
    input wire logic                      clk,
    input wire logic                      arst_n,
    input wire cfg_wdt_pkg::table_req_t   table_req,
    input wire cfg_wdt_pkg::core_event_t  core_evt,
    input wire logic [7:0]                table_latch_low,
    input wire logic [7:0]                table_latch_high,
    input wire logic                      table_hit,
    input wire logic [7:0]                cpu_status_register,
    input wire logic                      wdt_reset_req,
    input wire cfg_wdt_pkg::cfg_decoded_t cfg_decoded,
    input wire logic                      cfg_in_space
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_hi; table_hit |-> table_latch_high == 8'hff; endproperty
    a_hi: assert property (p_hi) else $error("latch high not ff");
    property p_src; table_hit |-> $past(table_req.rd) && $past(table_req.addr[15:4]) == 12'hfe0;
    endproperty
    a_src: assert property (p_src) else $error("hit without read");
    property p_lat; $changed(table_latch_low) |-> table_hit; endproperty
    a_lat: assert property (p_lat) else $error("latch moved alone");
    property p_spc; cfg_in_space |-> cfg_decoded.processor_mode inside
        {cfg_wdt_pkg::PM_MICROCONTROLLER, cfg_wdt_pkg::PM_PROTECTED_MCU}; endproperty
    a_spc: assert property (p_spc) else $error("space in wrong mode");
    property p_one; wdt_reset_req |=> !wdt_reset_req; endproperty
    a_one: assert property (p_one) else $error("reset request too long");
    property p_to; wdt_reset_req |-> !cpu_status_register[3]; endproperty
    a_to: assert property (p_to) else $error("timeout flag set");
    property p_slp; core_evt.sleep |=> cpu_status_register[3:2] == 2'b10; endproperty
    a_slp: assert property (p_slp) else $error("sleep flags wrong");
    property p_clr; core_evt.clear_wdt |=> !wdt_reset_req; endproperty
    a_clr: assert property (p_clr) else $error("clear did not stop");
endmodule
bind config_word_and_watchdog cfg_wdt_asserts chk (.clk(clk), .arst_n(arst_n),
    .table_req(table_req), .core_evt(core_evt), .table_latch_low(table_latch_low),
    .table_latch_high(table_latch_high), .table_hit(table_hit), .cfg_in_space(cfg_in_space),
    .cpu_status_register(cpu_status_register), .wdt_reset_req(wdt_reset_req),
    .cfg_decoded(cfg_decoded));

// >>> dv/core_model.sv
// Core model issuing clear-watchdog and sleep strobes.
// Assumes a zero clear period means the core stops clearing.
`timescale 1ns/1ps
module core_model (
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic [15:0]         clr_period,
    input  wire logic                sleep_req,
    output cfg_wdt_pkg::core_event_t core_evt
);
    logic [15:0] cnt_reg; // Cycles since last clear
    // Periodic clear well inside the watchdog period
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg  <= 16'h0000;
            core_evt <= '0;
        end else begin
            cnt_reg <= (cnt_reg == clr_period) ? 16'h0000 : cnt_reg + 16'h0001;
            core_evt.clear_wdt <= (clr_period != 16'h0000) && (cnt_reg == clr_period);
            core_evt.sleep <= sleep_req;
            core_evt.wake <= 1'b0;
        end
    end
endmodule

// >>> dv/testbench.sv
// Bench for the configuration word and watchdog block.
// Assumes an RC tick of 8 clocks and a short power-up count.
`timescale 1ns/1ps
module testbench;
    logic                      clk, arst_n, rc, vpp, tool, sleep_req, in_rst;
    logic [15:0]               clr_period;
    cfg_wdt_pkg::table_req_t   req;
    cfg_wdt_pkg::core_event_t  evt;
    cfg_wdt_pkg::cfg_decoded_t dec;
    logic [7:0]                lo, hi, sts;
    logic                      hit, wreq, hold, in_sp;
    int                        n_fail, n_checks, hits, reqs, t;
    config_word_and_watchdog #(.POWER_UP_TIMER_CYCLES(50)) dut (.clk(clk), .arst_n(arst_n),
        .wdt_rc_osc(rc), .prog_voltage_high(vpp), .prog_tool_mode(tool), .table_req(req),
        .core_evt(evt), .core_in_reset(in_rst), .sts_wr(1'b0), .sts_addr(8'h00),
        .sts_wdata(8'h00), .table_latch_low(lo), .table_latch_high(hi), .table_hit(hit),
        .cpu_status_register(sts), .wdt_reset_req(wreq), .power_up_hold(hold),
        .cfg_decoded(dec), .cfg_in_space(in_sp));
    core_model core (.clk(clk), .arst_n(arst_n), .clr_period(clr_period),
        .sleep_req(sleep_req), .core_evt(evt));
    initial begin clk = 0; forever #20 clk = ~clk; end
    initial begin rc = 0; forever #160 rc = ~rc; end
    // Count answer pulses
    always @(posedge clk) begin
        hits <= hits + (hit === 1'b1);
        reqs <= reqs + (wreq === 1'b1);
    end
    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    // One table read or write strobe, then settle
    task automatic acc(input logic w, input logic [15:0] a);
        @(posedge clk);
        req <= '{rd: !w, wr: w, addr: a, wdata: 16'hffff};
        @(posedge clk);
        req <= '0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic pins(input logic v, input logic tl);
        @(posedge clk);
        vpp <= v;
        tool <= tl;
        repeat (4) @(posedge clk);
    endtask
    task automatic give_verdict;
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin #3200000; n_fail++; give_verdict(); end
    initial begin
        {arst_n, vpp, tool, sleep_req, in_rst} = 5'h00;
        clr_period = 16'h0000;
        req = '0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (40) @(posedge clk);
        #1;
        chk(8'h3c, sts);
        chk(1'b1, hold);
        repeat (20) @(posedge clk);
        chk(1'b0, hold);
        $display("reset and power-up done");
        acc(0, 16'hfe00);
        chk(0, 16'(hits));
        pins(0, 1);
        acc(0, 16'hfe07);
        chk(8'hff, lo);
        chk(8'hff, hi);
        acc(0, 16'hfe08);
        chk(2, 16'(hits));
        pins(0, 0);
        acc(1, 16'hfe00);
        chk(cfg_wdt_pkg::OSC_EXTERNAL_CLOCK, dec.osc_mode);
        pins(1, 0);
        acc(1, 16'hfe00);
        acc(1, 16'hfe04);
        acc(1, 16'hfe0e);
        chk(cfg_wdt_pkg::OSC_CRYSTAL_RESONATOR, dec.osc_mode);
        chk(cfg_wdt_pkg::PM_MICROCONTROLLER, dec.processor_mode);
        chk(1'b0, dec.brownout_detect_enable);
        chk(1'b1, in_sp);
        pins(0, 0);
        acc(0, 16'hfe01);
        chk(8'hee, lo);
        acc(0, 16'hfe0f);
        chk(8'hbf, lo);
        $display("config word done");
        @(posedge clk);
        sleep_req <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(8'h38, sts);
        for (t = 0; reqs == 0 && t < 3000; t++) @(posedge clk);
        #1;
        chk(1'b1, t >= 2030 && t <= 2075);
        chk(8'h30, sts);
        chk(1, 16'(reqs));
        clr_period <= 16'd1000;
        repeat (1100) @(posedge clk);
        #1;
        chk(8'h3c, sts);
        repeat (4000) @(posedge clk);
        chk(1, 16'(reqs));
        $display("watchdog done");
        // Second reset in mid-run, then plain timer mode from a known start
        clr_period <= 16'h0000;
        in_rst <= 1'b1;
        arst_n <= 1'b0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (60) @(posedge clk);
        #1;
        chk(8'h3c, sts);
        chk(1'b0, hold);
        pins(1, 0);
        acc(1, 16'hfe02);
        acc(1, 16'hfe03);
        pins(0, 0);
        chk(cfg_wdt_pkg::WD_OFF_TIMER, dec.watchdog_postscale);
        in_rst <= 1'b0;
        repeat (65530) @(posedge clk);
        #1;
        chk(8'h3c, sts);
        repeat (10) @(posedge clk);
        #1;
        chk(8'h34, sts);
        chk(1, 16'(reqs));
        $display("timer mode done");
        give_verdict();
    end
endmodule
